// ===== inc/supervisor_alert_defs.vh
`ifndef SUPERVISOR_ALERT_DEFS_VH
`define SUPERVISOR_ALERT_DEFS_VH

// ----------------------------------------
// Register offsets (command byte values)
// ----------------------------------------
`define OFS_VOLT_DATA0 8'h20
`define OFS_TEMP_DATA 8'h27
`define OFS_LIMIT_FIRST 8'h2b
`define OFS_LIMIT_LAST 8'h3a
`define OFS_HOT_LIMIT 8'h39
`define OFS_HOT_HYST 8'h3a
`define OFS_CONFIG 8'h40
`define OFS_INT_STATUS 8'h41
`define OFS_INT_MASK 8'h43
`define OFS_SLAVE_ADDR 8'h48
`define OFS_TEMP_CONFIG 8'h4b

// ----------------------------------------
// Configuration register fields
// ----------------------------------------
`define CFG_RUN_BIT 0
`define CFG_ALERT_EN_BIT 1
`define CFG_ALERT_CLR_BIT 3
`define CFG_LINE50_BIT 4
`define CFG_OSR_LOW_BIT 5
`define CFG_SOFT_RST_BIT 7
`define CFG_STORE_MASK 8'h3b

// ----------------------------------------
// Temperature configuration and status fields
// ----------------------------------------
`define TMODE_DEFAULT 2'h0
`define TMODE_ONE_TIME 2'h1
`define TMODE_COMPARATOR 2'h2
`define TMODE_DEFAULT_ALT 2'h3
`define STAT_TEMP_BIT 4
`define STAT_VALID_MASK 8'h1f

// ----------------------------------------
// Reset values
// ----------------------------------------
`define RST_CONFIG 8'h00
`define RST_TEMP_CONFIG 8'h00
`define RST_INT_MASK 8'h00
`define RST_INT_STATUS 8'h00
`define RST_HOT_LIMIT 8'h50
`define RST_HOT_HYST 8'h41
`define RST_VOLT_HIGH 8'hd3
`define RST_VOLT_LOW 8'had
`define RST_UNUSED_LIMIT 8'h00

// ----------------------------------------
// Alert response timing
// ----------------------------------------
`define ARA_BITS 4'h8

`endif

// ===== core/limit_store.v
`timescale 1ns/100ps
`default_nettype none
`include "supervisor_alert_defs.vh"

// ----------------------------------------
// Limit memory, indices 0..15 map to offsets 2Bh..3Ah
// ----------------------------------------
module limit_store #(
	parameter DEPTH = 16,
	parameter AW = 4
) (
	// Clock and reset
	input wire clk_sys,
	input wire nrst,
	input wire soft_rst,
	// Write side
	input wire wr_en,
	input wire [AW-1:0] wr_idx,
	input wire [7:0] wr_data,
	// Read side, data registered
	input wire [AW-1:0] rd_idx,
	output reg [7:0] rd_data_q
);

	reg [7:0] mem_q [0:DEPTH-1];
	integer i;

	// Power-up value of each entry; even voltage slots hold high limits
	function [7:0] limit_default;
		input integer idx;
		begin
			if (idx < 8)
				limit_default = (idx % 2 == 0) ? `RST_VOLT_HIGH : `RST_VOLT_LOW;
			else if (idx == (`OFS_HOT_LIMIT - `OFS_LIMIT_FIRST))
				limit_default = `RST_HOT_LIMIT;
			else if (idx == (`OFS_HOT_HYST - `OFS_LIMIT_FIRST))
				limit_default = `RST_HOT_HYST;
			else
				limit_default = `RST_UNUSED_LIMIT;
		end
	endfunction

	// Storage; soft reset restores every entry like power-up
	always @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			for (i = 0; i < DEPTH; i = i + 1)
				mem_q[i] <= limit_default(i);
		end else if (soft_rst) begin
			for (i = 0; i < DEPTH; i = i + 1)
				mem_q[i] <= limit_default(i); // R12
		end else if (wr_en) begin
			mem_q[wr_idx] <= wr_data;
		end
	end

	// Registered read port
	always @(posedge clk_sys or negedge nrst) begin
		if (!nrst)
			rd_data_q <= 8'h00;
		else
			rd_data_q <= mem_q[rd_idx];
	end

endmodule // limit_store

`default_nettype wire

// ===== core/supervisor_alert_config_control.v
`timescale 1ns/100ps
`default_nettype none
`include "supervisor_alert_defs.vh"

// Summary of operation
// R01: On alert response, send own address bitwise; lower address wins arbitration.
// R02: After losing arbitration, stop driving and keep the alert line low.
// R03: Answering the alert response address never clears the alert.
// R04: Host clears or masks this alert before identifying other alerting slaves.
// R05: An 8-bit command byte selects the register for later reads and writes.
// R06: Config bit 0 stops or starts monitoring; register port always works.
// R07: Host should program all limits before setting the run bit.
// R08: Config bit 1 enables the alert output.
// R09: Config bit 3 drops the alert and stops monitoring; status kept.
// R10: Config bit 4 selects 50Hz (1) or 60Hz (0) line rejection.
// R11: Config bit 5 drops oversampling from eight to two, faster cycle.
// R12: Writing config bit 7 restores all registers; bit 7 reads back 0. The code keeps a written slave address.
// R13: Temperature config bits 1:0 pick mode; 11 acts as default; 7:2 stored.
// R14: Default mode: interrupt each conversion from above hot until below hysteresis.
// R15: One-time mode: interrupt on crossing above hot, then below hysteresis.
// R16: Comparator mode: temperature status follows fault; reads do not clear it.
// R17: Status bits 0-3 flag 2.5V, 12V, 3.3V, supply; bit 4 temperature.
// R18: Alert asserts for unmasked set status with enable on and no clear.
module supervisor_alert_config_control #(
	parameter [4:0] ADDR_HIGH = 5'h0a, // Upper address bits, arbitrary default
	parameter LIMIT_AW = 4
) (
	// Clock and reset
	input wire clk_sys,
	input wire nrst,
	// Byte register port from the serial front end
	input wire cmd_wr,
	input wire data_wr,
	input wire data_rd,
	input wire [7:0] wr_byte,
	output reg [7:0] rd_byte_q,
	output reg rd_valid_q,
	// Measurement results from the converter sequencer
	input wire conv_done,
	input wire [3:0] volt_fault,
	input wire [31:0] volt_reading,
	input wire [7:0] temp_reading,
	// Alert response arbitration
	input wire ara_begin,
	input wire ara_bit,
	input wire sda_pin,
	output reg ara_sda_o_q,
	output reg ara_sda_oe_q,
	output reg ara_active_q,
	output reg ara_lost_q,
	// Address strap pins and resulting address
	input wire [1:0] addr_strap,
	output reg [6:0] slave_addr_q,
	// Converter control
	output reg monitor_run_q,
	output reg line_50hz_q,
	output reg osr_low_q,
	// Open-drain alert line, low when enabled
	output reg alert_n_o_q,
	output reg alert_n_oe_q
);

	// ----------------------------------------
	// Helpers
	// ----------------------------------------

	// True when a command byte points into the limit memory
	function in_limits;
		input [7:0] cmd;
		begin
			in_limits = (cmd >= `OFS_LIMIT_FIRST) && (cmd <= `OFS_LIMIT_LAST);
		end
	endfunction

	// Index into the limit memory for a command byte
	function [LIMIT_AW-1:0] limit_idx;
		input [7:0] cmd;
		reg [7:0] diff;
		begin
			diff = cmd - `OFS_LIMIT_FIRST;
			limit_idx = diff[LIMIT_AW-1:0];
		end
	endfunction

	// ----------------------------------------
	// State
	// ----------------------------------------
	reg [7:0] cmd_q;
	reg [7:0] config_q;
	reg [7:0] temp_config_q;
	reg [7:0] int_mask_q;
	reg [7:0] int_status_q;
	reg over_hot_q;
	reg soft_rst_q;
	reg addr_override_q;
	reg [6:0] addr_written_q;
	reg [1:0] strap_meta_q;
	reg [1:0] strap_sync_q;
	reg sda_meta_q;
	reg sda_sync_q;
	reg [7:0] ara_shift_q;
	reg [3:0] ara_count_q;
	wire [7:0] limit_rdata;

	// ----------------------------------------
	// Decode
	// ----------------------------------------
	wire wr_config = data_wr && (cmd_q == `OFS_CONFIG);
	wire wr_limit = data_wr && in_limits(cmd_q);
	wire rd_status = data_rd && (cmd_q == `OFS_INT_STATUS);
	wire [1:0] temp_mode = temp_config_q[1:0];
	wire mode_one_time = (temp_mode == `TMODE_ONE_TIME); // R13
	wire mode_comparator = (temp_mode == `TMODE_COMPARATOR); // R13
	wire [7:0] hot_limit;
	wire [7:0] hot_temp_hysteresis;
	wire above_hot = $signed(temp_reading) > $signed(hot_limit);
	wire below_hyst = $signed(temp_reading) < $signed(hot_temp_hysteresis);

	// Hot limit and hysteresis are kept as flops beside the memory copy so
	// the comparator need not share the memory read port with the host
	reg [7:0] hot_limit_q;
	reg [7:0] hot_hyst_q;
	assign hot_limit = hot_limit_q;
	assign hot_temp_hysteresis = hot_hyst_q;

	always @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			hot_limit_q <= `RST_HOT_LIMIT;
			hot_hyst_q <= `RST_HOT_HYST;
		end else if (soft_rst_q) begin
			hot_limit_q <= `RST_HOT_LIMIT;
			hot_hyst_q <= `RST_HOT_HYST;
		end else if (data_wr && cmd_q == `OFS_HOT_LIMIT) begin
			hot_limit_q <= wr_byte;
		end else if (data_wr && cmd_q == `OFS_HOT_HYST) begin
			hot_hyst_q <= wr_byte;
		end
	end

	// ----------------------------------------
	// Limit memory
	// ----------------------------------------
	limit_store #(
		.DEPTH(16),
		.AW(LIMIT_AW)
	) u_limits (
		.clk_sys(clk_sys),
		.nrst(nrst),
		.soft_rst(soft_rst_q),
		.wr_en(wr_limit),
		.wr_idx(limit_idx(cmd_q)),
		.wr_data(wr_byte),
		.rd_idx(limit_idx(cmd_q)),
		.rd_data_q(limit_rdata)
	);

	// ----------------------------------------
	// Pin synchronisers
	// ----------------------------------------
	always @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			strap_meta_q <= 2'h0;
			strap_sync_q <= 2'h0;
			sda_meta_q <= 1'b1;
			sda_sync_q <= 1'b1;
		end else begin
			strap_meta_q <= addr_strap;
			strap_sync_q <= strap_meta_q;
			sda_meta_q <= sda_pin;
			sda_sync_q <= sda_meta_q;
		end
	end

	// ----------------------------------------
	// Command byte and control registers
	// ----------------------------------------

	// Command index survives soft reset so the host keeps its pointer
	always @(posedge clk_sys or negedge nrst) begin
		if (!nrst)
			cmd_q <= 8'h00;
		else if (cmd_wr)
			cmd_q <= wr_byte; // R05
	end

	// Soft reset pulse one cycle after the write; bit 7 itself never stored
	always @(posedge clk_sys or negedge nrst) begin
		if (!nrst)
			soft_rst_q <= 1'b0;
		else
			soft_rst_q <= wr_config && wr_byte[`CFG_SOFT_RST_BIT]; // R12
	end

	// Configuration, temperature configuration and mask registers
	always @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			config_q <= `RST_CONFIG;
			temp_config_q <= `RST_TEMP_CONFIG;
			int_mask_q <= `RST_INT_MASK;
		end else if (soft_rst_q) begin
			config_q <= `RST_CONFIG; // R12
			temp_config_q <= `RST_TEMP_CONFIG;
			int_mask_q <= `RST_INT_MASK;
		end else if (data_wr) begin
			if (cmd_q == `OFS_CONFIG)
				config_q <= wr_byte & `CFG_STORE_MASK;
			if (cmd_q == `OFS_TEMP_CONFIG)
				temp_config_q <= wr_byte; // R13
			if (cmd_q == `OFS_INT_MASK)
				int_mask_q <= wr_byte & `STAT_VALID_MASK;
		end
	end

	// Written address overrides the strap until a power-on reset only
	always @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			addr_override_q <= 1'b0;
			addr_written_q <= 7'h00;
		end else if (data_wr && cmd_q == `OFS_SLAVE_ADDR) begin
			addr_override_q <= 1'b1;
			addr_written_q <= wr_byte[6:0];
		end
	end

	always @(posedge clk_sys or negedge nrst) begin
		if (!nrst)
			slave_addr_q <= 7'h00;
		else
			slave_addr_q <= addr_override_q ? addr_written_q : {ADDR_HIGH, strap_sync_q};
	end

	// Converter control outputs
	always @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			monitor_run_q <= 1'b0;
			line_50hz_q <= 1'b0;
			osr_low_q <= 1'b0;
		end else begin
			monitor_run_q <= config_q[`CFG_RUN_BIT] && !config_q[`CFG_ALERT_CLR_BIT]; // R06 R09
			line_50hz_q <= config_q[`CFG_LINE50_BIT]; // R10
			osr_low_q <= config_q[`CFG_OSR_LOW_BIT]; // R11
		end
	end

	// ----------------------------------------
	// Temperature tracking and interrupt status
	// ----------------------------------------
	wire over_hot_d = above_hot ? 1'b1 : (below_hyst ? 1'b0 : over_hot_q);
	wire temp_event_default = over_hot_d; // R14
	wire temp_event_once = over_hot_d != over_hot_q; // R15
	wire temp_event = mode_one_time ? temp_event_once : temp_event_default;
	wire [4:0] set_bits = {temp_event && !mode_comparator, volt_fault}
		& ~int_mask_q[4:0] & {5{conv_done}}; // R17
	wire [4:0] clr_bits = rd_status ? {!mode_comparator, 4'hf} : 5'h00;

	// Hot/hysteresis band state, updated once per conversion
	always @(posedge clk_sys or negedge nrst) begin
		if (!nrst)
			over_hot_q <= 1'b0;
		else if (soft_rst_q)
			over_hot_q <= 1'b0;
		else if (conv_done)
			over_hot_q <= over_hot_d;
	end

	// New events win over a clearing status read in the same cycle
	always @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			int_status_q <= `RST_INT_STATUS;
		end else if (soft_rst_q) begin
			int_status_q <= `RST_INT_STATUS;
		end else begin
			int_status_q[3:0] <= (int_status_q[3:0] & ~clr_bits[3:0]) | set_bits[3:0];
			if (mode_comparator) begin
				if (conv_done)
					int_status_q[4] <= above_hot && !int_mask_q[4]; // R16
			end else begin
				int_status_q[4] <= (int_status_q[4] & ~clr_bits[4]) | set_bits[4]; // R14 R15
			end
			int_status_q[7:5] <= 3'h0;
		end
	end

	// ----------------------------------------
	// Alert line
	// ----------------------------------------

	// The alert response machine never touches status, so answering it
	// leaves the line asserted; a losing device also keeps holding it
	always @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			alert_n_o_q <= 1'b0;
			alert_n_oe_q <= 1'b0;
		end else begin
			alert_n_o_q <= 1'b0;
			alert_n_oe_q <= (|(int_status_q[4:0] & ~int_mask_q[4:0]))
				&& config_q[`CFG_ALERT_EN_BIT] // R08
				&& !config_q[`CFG_ALERT_CLR_BIT]; // R18 R09 R03 R02
		end
	end

	// ----------------------------------------
	// Alert response arbitration
	// ----------------------------------------

	// Sends {address, 0} MSB first; drives low for a 0 and releases for a
	// 1, and drops out when a released bit is seen pulled low by a peer
	always @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			ara_shift_q <= 8'h00;
			ara_count_q <= 4'h0;
			ara_active_q <= 1'b0;
			ara_lost_q <= 1'b0;
			ara_sda_o_q <= 1'b0;
			ara_sda_oe_q <= 1'b0;
		end else if (ara_begin) begin
			ara_shift_q <= {slave_addr_q, 1'b0};
			ara_count_q <= `ARA_BITS;
			ara_active_q <= alert_n_oe_q;
			ara_lost_q <= 1'b0;
			ara_sda_o_q <= 1'b0;
			ara_sda_oe_q <= alert_n_oe_q && !slave_addr_q[6]; // R01
		end else if (ara_bit && ara_active_q) begin
			if (ara_shift_q[7] && !sda_sync_q) begin
				ara_active_q <= 1'b0; // R02
				ara_lost_q <= 1'b1; // R01
				ara_sda_oe_q <= 1'b0; // R02
				ara_count_q <= 4'h0;
			end else if (ara_count_q == 4'h1) begin
				ara_active_q <= 1'b0;
				ara_sda_oe_q <= 1'b0;
				ara_count_q <= 4'h0;
			end else begin
				ara_shift_q <= {ara_shift_q[6:0], 1'b0};
				ara_count_q <= ara_count_q - 4'h1;
				ara_sda_oe_q <= !ara_shift_q[6]; // R01
			end
		end
	end

	// ----------------------------------------
	// Register read path
	// ----------------------------------------

	// Limit data comes from the memory's registered port, so a read must
	// follow a command write by at least two cycles
	always @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			rd_byte_q <= 8'h00;
			rd_valid_q <= 1'b0;
		end else begin
			rd_valid_q <= data_rd;
			if (data_rd) begin
				if (in_limits(cmd_q))
					rd_byte_q <= limit_rdata;
				else if (cmd_q >= `OFS_VOLT_DATA0 && cmd_q < `OFS_VOLT_DATA0 + 8'h04)
					rd_byte_q <= volt_reading[{cmd_q[1:0], 3'h0} +: 8];
				else
					case (cmd_q)
					`OFS_TEMP_DATA: rd_byte_q <= temp_reading;
					`OFS_CONFIG: rd_byte_q <= config_q; // R12
					`OFS_INT_STATUS: rd_byte_q <= int_status_q;
					`OFS_INT_MASK: rd_byte_q <= int_mask_q;
					`OFS_SLAVE_ADDR: rd_byte_q <= {1'b0, slave_addr_q};
					`OFS_TEMP_CONFIG: rd_byte_q <= temp_config_q;
					default: rd_byte_q <= 8'h00;
					endcase
			end
		end
	end

endmodule // supervisor_alert_config_control

`default_nettype wire

// ===== tb/supervisor_alert_props.sv
`timescale 1ns/100ps
`default_nettype none
`include "supervisor_alert_defs.vh"

// ------
// Port checker for the alert and config block
// ------
module supervisor_alert_props (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic nrst,
	// Register port
	input wire logic cmd_wr,
	input wire logic data_wr,
	input wire logic data_rd,
	input wire logic [7:0] wr_byte,
	input wire logic rd_valid_q,
	// Alert response and outputs
	input wire logic ara_begin,
	input wire logic ara_sda_o_q,
	input wire logic ara_sda_oe_q,
	input wire logic ara_active_q,
	input wire logic ara_lost_q,
	input wire logic [6:0] slave_addr_q,
	input wire logic monitor_run_q,
	input wire logic line_50hz_q,
	input wire logic osr_low_q,
	input wire logic alert_n_o_q,
	input wire logic alert_n_oe_q
);
	logic [7:0] cmd_q;
	logic [3:0] quiet_q;
	logic cfg_wr;

	// Shadow of the index, and cycles since the last data access (a read may clear the alert)
	always @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			cmd_q <= 8'h00;
			quiet_q <= 4'h0;
		end else begin
			if (cmd_wr) cmd_q <= wr_byte;
			if (data_wr || data_rd) quiet_q <= 4'h0;
			else if (quiet_q != 4'hf) quiet_q <= quiet_q + 4'h1;
		end
	end
	assign cfg_wr = data_wr && (cmd_q == `OFS_CONFIG);

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!nrst);

	AST_RD_VALID: assert property (rd_valid_q == $past(data_rd))
		else $error("read valid not one cycle after read strobe");
	AST_CFG_RUN: assert property (cfg_wr && !wr_byte[7] |->
		##2 monitor_run_q == ($past(wr_byte[0], 2) && !$past(wr_byte[3], 2)))
		else $error("run output does not follow config bits 0 and 3");
	AST_CFG_SPEED: assert property (cfg_wr && !wr_byte[7] |->
		##2 line_50hz_q == $past(wr_byte[4], 2) && osr_low_q == $past(wr_byte[5], 2))
		else $error("speed outputs do not follow config bits 4 and 5");
	AST_ALERT_GATE: assert property (cfg_wr && (!wr_byte[1] || wr_byte[3]) |->
		##2 !alert_n_oe_q [*3])
		else $error("alert driven while disabled or cleared");
	AST_ODRAIN: assert property (!alert_n_o_q && !ara_sda_o_q)
		else $error("open-drain output level not low");
	AST_ARA_IGNORE: assert property (ara_begin && !alert_n_oe_q |=> !ara_active_q)
		else $error("alert response joined while not alerting");
	AST_ARA_FIRST: assert property (ara_begin && alert_n_oe_q |=>
		ara_active_q && ara_sda_oe_q == !slave_addr_q[6])
		else $error("first returned address bit wrong");
	AST_ARA_LOSE: assert property ($rose(ara_lost_q) |-> !$past(ara_sda_oe_q))
		else $error("lost arbitration while driving low");
	AST_ARA_QUIET: assert property (ara_lost_q |-> !ara_sda_oe_q && !ara_active_q)
		else $error("data line driven after losing");
	AST_ARA_KEEP: assert property ($fell(ara_active_q) && quiet_q == 4'hf |-> alert_n_oe_q)
		else $error("alert response cleared the alert");
	AST_SOFT_RST: assert property (cfg_wr && wr_byte[7] |->
		##4 !monitor_run_q && !line_50hz_q && !osr_low_q && !alert_n_oe_q)
		else $error("soft reset left config outputs set");

	COV_ARA: cover property (ara_begin && alert_n_oe_q);
	COV_LOST: cover property ($rose(ara_lost_q));
	COV_SOFT: cover property (cfg_wr && wr_byte[7]);
endmodule // supervisor_alert_props

bind supervisor_alert_config_control supervisor_alert_props i_props (
	.clk_sys(clk_sys), .nrst(nrst), .cmd_wr(cmd_wr), .data_wr(data_wr), .data_rd(data_rd),
	.wr_byte(wr_byte), .rd_valid_q(rd_valid_q), .ara_begin(ara_begin),
	.ara_sda_o_q(ara_sda_o_q), .ara_sda_oe_q(ara_sda_oe_q), .ara_active_q(ara_active_q),
	.ara_lost_q(ara_lost_q), .slave_addr_q(slave_addr_q), .monitor_run_q(monitor_run_q),
	.line_50hz_q(line_50hz_q), .osr_low_q(osr_low_q), .alert_n_o_q(alert_n_o_q),
	.alert_n_oe_q(alert_n_oe_q)
);
`default_nettype wire

// ===== tb/smbus_ara_host.sv
`timescale 1ns/100ps
`default_nettype none

// ------
// Host plus one competing slave on the alert response
// ------
module smbus_ara_host (
	// Clock
	input wire logic clk_sys,
	// Shared data line
	input wire logic dut_oe,
	output logic ara_begin,
	output logic ara_bit,
	output logic sda_pin
);
	logic peer_oe = 1'b0;
	logic peer_in = 1'b0;
	logic [7:0] frame;

	// Wired-AND with pull-up, so a released line reads high
	assign sda_pin = !(dut_oe || peer_oe);
	initial begin
		ara_begin = 1'b0;
		ara_bit = 1'b0;
	end

	// One response frame: peer address MSB first then a 0, bit sampled after settling
	task run(input [6:0] peer_addr, input bit enable);
		integer k;
		begin
			frame = {peer_addr, 1'b0};
			peer_in = enable;
			@(negedge clk_sys);
			ara_begin = 1'b1;
			@(negedge clk_sys);
			ara_begin = 1'b0;
			for (k = 7; k >= 0; k--) begin
				peer_oe = peer_in && !frame[k];
				repeat (4) @(negedge clk_sys);
				if (peer_in && frame[k] && !sda_pin) peer_in = 1'b0;
				ara_bit = 1'b1;
				@(negedge clk_sys);
				ara_bit = 1'b0;
			end
			peer_oe = 1'b0;
		end
	endtask
endmodule // smbus_ara_host
`default_nettype wire

// ===== tb/supervisor_alert_config_control_tb.sv
`timescale 1ns/100ps
`default_nettype none
`include "supervisor_alert_defs.vh"

module supervisor_alert_config_control_tb;
	localparam [4:0] ADDR_HIGH = 5'h0a; // Arbitrary upper address bits
	logic clk_sys = 1'b0;
	logic nrst = 1'b0;
	logic cmd_wr = 1'b0, data_wr = 1'b0, data_rd = 1'b0, conv_done = 1'b0;
	logic [7:0] wr_byte = 8'h00, temp_reading = 8'h00, d, v, mk;
	logic [3:0] volt_fault = 4'h0;
	logic [31:0] volt_reading = 32'h0;
	logic [1:0] addr_strap = 2'h0;
	logic [6:0] pa;
	wire [7:0] rd_byte_q;
	wire [6:0] slave_addr_q;
	wire rd_valid_q, ara_sda_o_q, ara_sda_oe_q, ara_active_q, ara_lost_q, monitor_run_q;
	wire line_50hz_q, osr_low_q, alert_n_o_q, alert_n_oe_q, ara_begin, ara_bit, sda_pin;
	integer seed = 81168, num_errors = 0, checks = 0, cycles = 0, i, m, s;

	// ------
	// Clock, design and far side
	// ------
	always #20 clk_sys = ~clk_sys;
	supervisor_alert_config_control #(.ADDR_HIGH(ADDR_HIGH), .LIMIT_AW(4)) i_dut (
		.clk_sys(clk_sys), .nrst(nrst), .cmd_wr(cmd_wr), .data_wr(data_wr),
		.data_rd(data_rd), .wr_byte(wr_byte), .rd_byte_q(rd_byte_q), .rd_valid_q(rd_valid_q),
		.conv_done(conv_done), .volt_fault(volt_fault), .volt_reading(volt_reading),
		.temp_reading(temp_reading), .ara_begin(ara_begin), .ara_bit(ara_bit),
		.sda_pin(sda_pin), .ara_sda_o_q(ara_sda_o_q), .ara_sda_oe_q(ara_sda_oe_q),
		.ara_active_q(ara_active_q), .ara_lost_q(ara_lost_q), .addr_strap(addr_strap),
		.slave_addr_q(slave_addr_q), .monitor_run_q(monitor_run_q),
		.line_50hz_q(line_50hz_q), .osr_low_q(osr_low_q), .alert_n_o_q(alert_n_o_q),
		.alert_n_oe_q(alert_n_oe_q));
	smbus_ara_host i_host (.clk_sys(clk_sys), .dut_oe(ara_sda_oe_q), .ara_begin(ara_begin),
		.ara_bit(ara_bit), .sda_pin(sda_pin));

	// ------
	// Bus tasks, compare and expectations
	// ------
	task wr(input [7:0] a, input [7:0] b);
		begin
			@(negedge clk_sys); cmd_wr = 1'b1; wr_byte = a;
			@(negedge clk_sys); cmd_wr = 1'b0; data_wr = 1'b1; wr_byte = b;
			@(negedge clk_sys); data_wr = 1'b0;
		end
	endtask
	// Read leaves a spare cycle after the index for the limit memory latency
	task rd(input [7:0] a, output [7:0] b);
		begin
			@(negedge clk_sys); cmd_wr = 1'b1; wr_byte = a;
			@(negedge clk_sys); cmd_wr = 1'b0;
			@(negedge clk_sys); data_rd = 1'b1;
			@(negedge clk_sys); data_rd = 1'b0; b = rd_byte_q;
		end
	endtask
	task conv(input [3:0] f, input [7:0] t);
		begin
			@(negedge clk_sys); volt_fault = f; temp_reading = t; conv_done = 1'b1;
			@(negedge clk_sys); conv_done = 1'b0;
			repeat (2) @(negedge clk_sys);
		end
	endtask
	task chk(input [7:0] got, input [7:0] exp);
		begin
			checks = checks + 1;
			if (got !== exp) begin
				num_errors = num_errors + 1;
				$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
			end
		end
	endtask
	function automatic [15:0] rst_ent(input integer k);
		case (k)
			0: rst_ent = {`OFS_CONFIG, `RST_CONFIG};
			1: rst_ent = {`OFS_TEMP_CONFIG, `RST_TEMP_CONFIG};
			2: rst_ent = {`OFS_INT_MASK, `RST_INT_MASK};
			3: rst_ent = {`OFS_INT_STATUS, `RST_INT_STATUS};
			4: rst_ent = {`OFS_HOT_LIMIT, `RST_HOT_LIMIT};
			default: rst_ent = {`OFS_HOT_HYST, `RST_HOT_HYST};
		endcase
	endfunction
	// Temperature status: steps are above hot, above hot again, below hysteresis
	function automatic [7:0] t_exp(input integer md, input integer st, input bit again);
		t_exp = (st == 0 || ((st == 1) != (md == 1))) ? 8'h10 : 8'h00;
		if (again && md != 2) t_exp = 8'h00;
	endfunction
	task summarize;
		begin
			$display("checks=%0d num_errors=%0d", checks, num_errors);
			if (num_errors == 0 && checks > 0) $display("ALL TESTS PASSED");
			else $display("TESTS FAILED");
			$finish;
		end
	endtask
	// Ceiling well above the roughly six hundred cycles the sequence takes
	always @(posedge clk_sys) begin
		cycles = cycles + 1;
		if (cycles == 20000) begin
			num_errors = num_errors + 1;
			summarize();
		end
	end

	// ------
	// Test sequence
	// ------
	initial begin
		addr_strap = 2'($random(seed));
		volt_reading = $random(seed);
		repeat (5) @(negedge clk_sys);
		nrst = 1'b1;
		repeat (4) @(negedge clk_sys);
		for (i = 0; i < 6; i++) begin
			rd(rst_ent(i) >> 8, d);
			chk(d, rst_ent(i) & 16'hff);
		end
		chk({1'b0, slave_addr_q}, {1'b0, ADDR_HIGH, addr_strap});
		for (i = 0; i < 4; i++) begin
			rd(`OFS_VOLT_DATA0 + 8'(i), d);
			chk(d, volt_reading[8*i +: 8]);
		end
		rd(8'h10, d);
		chk(d, 8'h00);
		$display("power-up and index test done");
		for (i = 0; i < 8; i++) begin
			v = (i == 0) ? 8'h01 : (i == 1) ? 8'h09 : 8'($random(seed)) & 8'h7f;
			wr(`OFS_CONFIG, v);
			rd(`OFS_CONFIG, d);
			chk(d, v & `CFG_STORE_MASK);
			chk({monitor_run_q, line_50hz_q, osr_low_q}, {v[0] & !v[3], v[4], v[5]});
		end
		wr(`OFS_HOT_LIMIT, 8'($random(seed)));
		wr(`OFS_CONFIG, 8'h80);
		rd(`OFS_CONFIG, d);
		chk(d, `RST_CONFIG);
		rd(`OFS_HOT_LIMIT, d);
		chk(d, `RST_HOT_LIMIT);
		$display("config test done");
		for (m = 0; m < 4; m++) begin
			v = {6'($random(seed)), 2'(m)};
			wr(`OFS_TEMP_CONFIG, v);
			rd(`OFS_TEMP_CONFIG, d);
			chk(d, v);
			wr(`OFS_CONFIG, 8'h03);
			for (s = 0; s < 3; s++) begin
				conv(4'h0, (s == 2) ? 8'h30 : 8'h60);
				chk(alert_n_oe_q, |t_exp(m, s, 0));
				rd(`OFS_INT_STATUS, d);
				chk(d, t_exp(m, s, 0));
				rd(`OFS_INT_STATUS, d);
				chk(d, t_exp(m, s, 1));
			end
		end
		$display("temperature mode test done");
		for (i = 0; i < 6; i++) begin
			mk = (i == 0) ? 8'h00 : 8'($random(seed)) & 8'h1f;
			wr(`OFS_INT_MASK, mk);
			conv((i == 0) ? 4'hf : 4'($random(seed)), 8'h30);
			chk(alert_n_oe_q, |(volt_fault & ~mk[3:0]));
			rd(`OFS_INT_STATUS, d);
			chk(d, {4'h0, volt_fault & ~mk[3:0]});
		end
		wr(`OFS_INT_MASK, 8'h00);
		conv(4'h5, 8'h30);
		wr(`OFS_CONFIG, 8'h0b);
		repeat (2) @(negedge clk_sys);
		chk({alert_n_oe_q, monitor_run_q}, 8'h00);
		rd(`OFS_INT_STATUS, d);
		chk(d, 8'h05);
		wr(`OFS_CONFIG, 8'h03);
		$display("voltage and clear test done");
		for (i = 0; i < 3; i++) begin
			conv(4'h1, 8'h30);
			pa = (i == 0) ? slave_addr_q - 7'h1 : slave_addr_q + 7'h1;
			i_host.run(pa, i != 2);
			repeat (2) @(negedge clk_sys);
			chk(ara_lost_q, i == 0);
			chk(alert_n_oe_q, 8'h01);
		end
		wr(`OFS_INT_MASK, 8'h01);
		repeat (2) @(negedge clk_sys);
		chk(alert_n_oe_q, 8'h00);
		rd(`OFS_INT_STATUS, d);
		wr(`OFS_INT_MASK, 8'h00);
		i_host.run(pa, 1'b1);
		chk({ara_active_q, ara_lost_q}, 8'h00);
		$display("alert response test done");
		summarize();
	end
endmodule // supervisor_alert_config_control_tb
`default_nettype wire
